// [system_control_insn_decoder.sv]
// decoder for system-control, cache-maintenance and address operations
`timescale 1ns/1ps

// How it works
// - translation on: effective addresses become physical
// - multi-space mode with translation on adds page-entry space identifier
// - displacement scaled by operand size
// - status-word load is privileged, T from lsb
// - global-base load is unprivileged, T untouched
// - vector, saved-pc, debug base loads privileged
// - saved-status-word load is privileged
// - banked register load, n 0..7, privileged
// - status-word pop sets T, adds four
// - banked register pop adds four, privileged
// - mul-acc-low load is unprivileged
// - link register pop adds four, unprivileged
// - store-allocate without line fill
// - no-operation changes nothing
// - three operand-line maintenance encodings recognised
// - fill hint brings block into operand cache
// - double precision makes FxxE undefined
// - f0000000-f7ffffff maps to internal arrays
// - e0000000-e3ffffff maps to store queue
// - fffd is undefined, raises exception
// - two instructions may issue together
// - two logical ors never issue together
// - every instruction word is sixteen bits
module system_control_insn_decoder #(
   parameter int INSN_W = 16,
   parameter int DISP_W = 4
) (
   input wire logic pclk,                      // core clock
   input wire logic presetn,                   // async reset, low
   input wire logic psel,                      // apb select
   input wire logic penable,                   // apb enable
   input wire logic pwrite,                    // apb direction
   input wire logic [31:0] paddr,              // apb address
   input wire logic [31:0] pwdata,             // apb write data
   output logic [31:0] prdata,                 // apb read data
   output logic pready,                        // apb ready
   output logic pslverr,                       // apb error
   input wire logic insn0_valid,               // first word present
   input wire logic [INSN_W-1:0] insn0,        // first word
   input wire logic insn1_valid,               // second word present
   input wire logic [INSN_W-1:0] insn1,        // second word
   input wire sysctl_pkg::ea_req_s ea_in,      // address request
   output sysctl_pkg::dec_s dec0,              // decoded first slot
   output sysctl_pkg::dec_s dec1,              // decoded second slot
   output logic [1:0] issue_count,             // words issued
   output logic exc_illegal,                   // privilege fault pulse
   output logic exc_undef,                     // undefined code pulse
   output sysctl_pkg::ea_ans_s ea_out          // address answer
);
   import sysctl_pkg::*;

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (INSN_W != 16) begin : g_bad_width
      $error("instruction words must be sixteen bits");
   end
   if (DISP_W < 1 || DISP_W > 8) begin : g_bad_disp
      $error("displacement width must be 1 to 8");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [3:0] ctrl;
      logic [31:0] page_entry_high_reg;
      logic [31:0] frame;
      logic [7:0] illegal_cnt;
      logic [7:0] undef_cnt;
      dec_s dec0;
      dec_s dec1;
      logic [1:0] issue_count;
      logic exc_illegal;
      logic exc_undef;
      ea_ans_s ea;
   } state_s;

   state_s r;
   state_s next_r;

   // ---------------------------------------------------------------
   // decode of one word
   // ---------------------------------------------------------------
   function automatic dec_s decode(input logic [15:0] w, input logic ok,
                                   input logic user, input logic dp);
      dec_s d;
      d = '0;
      d.valid = ok;
      d.src = w[7:4];
      d.dst = w[11:8];
      d.bank = w[6:4];
      d.op = OP_NONE;
      for (int i = 0; i < NUM_PATS; i++) begin
         if ((w & PATS[i].mask) == PATS[i].match) begin
            d.op = PATS[i].op;
            d.t_from_lsb = PATS[i].t_from_lsb;
            d.post_inc = PATS[i].post_inc;
            d.priv_fault = PATS[i].priv & user;
         end
      end
      if (w == UNDEF_FIXED) begin
         d.undef = 1'b1;
      end
      if (dp && (w & UNDEF_DP_MASK) == UNDEF_DP_MATCH) begin
         d.undef = 1'b1;
      end
      if (d.undef) begin
         d.op = OP_UNDEF;
         d.t_from_lsb = 1'b0;
         d.post_inc = 1'b0;
         d.priv_fault = 1'b0;
      end
      if (d.priv_fault) begin
         d.op = OP_NONE;
         d.t_from_lsb = 1'b0;
         d.post_inc = 1'b0;
      end
      if (!ok) begin
         d = '0;
      end
      return d;
   endfunction

   // ---------------------------------------------------------------
   // address window classification
   // ---------------------------------------------------------------
   function automatic region_e classify(input logic [31:0] a);
      region_e rg;
      rg = REGION_EXTERNAL;
      if (a >= ARRAYS_LO && a <= ARRAYS_HI) begin
         rg = REGION_ARRAYS;
      end else if (a >= SQ_LO && a <= SQ_HI) begin
         rg = REGION_STORE_QUEUE;
      end
      return rg;
   endfunction

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   logic [7:0] word_addr;
   logic mapped;
   logic do_write;
   logic user;
   logic dp;
   logic both_or;
   logic [1:0] issued;
   logic [31:0] ea_virt;
   logic [31:0] disp_ext;
   dec_s d0;
   dec_s d1;

   always_comb begin
      next_r = r;
      word_addr = paddr[7:0];
      user = r.ctrl[CTRL_USER_MODE];
      dp = r.ctrl[CTRL_DOUBLE_PRECISION];

      // apb slave: one wait state, answer on second access cycle
      mapped = (paddr[31:8] == 24'h000000) &&
               (word_addr == OFF_CTRL ||
                word_addr == OFF_PAGE_ENTRY_HIGH ||
                word_addr == OFF_FRAME ||
                word_addr == OFF_STATUS);
      do_write = psel && penable && r.pready && pwrite && mapped;
      next_r.pready = psel && penable && !r.pready;
      next_r.pslverr = psel && penable && !r.pready && !mapped;
      next_r.prdata = '0;
      if (psel && penable && !r.pready && !pwrite) begin
         case (word_addr)
            OFF_CTRL: begin
               next_r.prdata = {28'h0000000, r.ctrl};
            end
            OFF_PAGE_ENTRY_HIGH: begin
               next_r.prdata = r.page_entry_high_reg;
            end
            OFF_FRAME: begin
               next_r.prdata = r.frame;
            end
            OFF_STATUS: begin
               next_r.prdata[STAT_ILLEGAL_LSB +: 8] = r.illegal_cnt;
               next_r.prdata[STAT_UNDEF_LSB +: 8] = r.undef_cnt;
               next_r.prdata[STAT_ISSUE_LSB +: 2] = r.issue_count;
            end
            default: begin
               next_r.prdata = '0;
            end
         endcase
      end
      if (do_write) begin
         case (word_addr)
            OFF_CTRL: begin
               next_r.ctrl = pwdata[3:0];
            end
            OFF_PAGE_ENTRY_HIGH: begin
               next_r.page_entry_high_reg = pwdata;
            end
            OFF_FRAME: begin
               next_r.frame = pwdata;
            end
            default: begin
               next_r.frame = r.frame;
            end
         endcase
      end

      // instruction slots
      d0 = decode(insn0, insn0_valid, user, dp);
      d1 = decode(insn1, insn1_valid && insn0_valid, user, dp);
      both_or = d0.op == OP_LOGIC_OR && d1.op == OP_LOGIC_OR;
      // a faulting first slot must not let the second run past it
      if (!d1.valid || both_or || d0.priv_fault || d0.undef) begin
         d1 = '0;
      end
      issued = {1'b0, d0.valid} + {1'b0, d1.valid};
      next_r.dec0 = d0;
      next_r.dec1 = d1;
      next_r.issue_count = issued;
      next_r.exc_illegal = d0.priv_fault || d1.priv_fault;
      next_r.exc_undef = d0.undef || d1.undef;
      if (next_r.exc_illegal && r.illegal_cnt != 8'hff) begin
         next_r.illegal_cnt = r.illegal_cnt + 8'h01;
      end
      if (next_r.exc_undef && r.undef_cnt != 8'hff) begin
         next_r.undef_cnt = r.undef_cnt + 8'h01;
      end

      // effective address, translation and windows
      disp_ext = {{(32-DISP_W){1'b0}}, ea_in.disp[DISP_W-1:0]};
      ea_virt = ea_in.base + (disp_ext << ea_in.size);
      next_r.ea.valid = ea_in.req;
      next_r.ea.region = classify(ea_virt);
      next_r.ea.phys = ea_virt;
      next_r.ea.space_id = '0;
      next_r.ea.space_valid = 1'b0;
      if (r.ctrl[CTRL_TRANSLATION_ON]) begin
         next_r.ea.phys = {r.frame[31:PAGE_LSB],
                           ea_virt[PAGE_LSB-1:0]};
         if (!r.ctrl[CTRL_SINGLE_SPACE]) begin
            next_r.ea.space_id =
               r.page_entry_high_reg[SPACE_ID_W-1:0];
            next_r.ea.space_valid = 1'b1;
         end
      end
      // the internal windows are never translated
      if (next_r.ea.region != REGION_EXTERNAL) begin
         next_r.ea.phys = ea_virt;
      end
      if (!ea_in.req) begin
         next_r.ea = '0;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.ctrl <= CTRL_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.prdata;
   assign pready = r.pready;
   assign pslverr = r.pslverr;
   assign dec0 = r.dec0;
   assign dec1 = r.dec1;
   assign issue_count = r.issue_count;
   assign exc_illegal = r.exc_illegal;
   assign exc_undef = r.exc_undef;
   assign ea_out = r.ea;

endmodule

// [sysctl_pkg.sv]
// shared constants and types for the system-control instruction decoder
package sysctl_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PAGE_ENTRY_HIGH = 8'h04;
   localparam logic [7:0] OFF_FRAME = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;

   localparam int CTRL_TRANSLATION_ON = 0;
   localparam int CTRL_SINGLE_SPACE = 1;
   localparam int CTRL_DOUBLE_PRECISION = 2;
   localparam int CTRL_USER_MODE = 3;
   localparam logic [3:0] CTRL_RESET = 4'h8;

   localparam int STAT_ILLEGAL_LSB = 0;
   localparam int STAT_UNDEF_LSB = 8;
   localparam int STAT_ISSUE_LSB = 16;
   localparam int PAGE_LSB = 12;
   localparam int SPACE_ID_W = 8;

   // ---------------------------------------------------------------
   // address windows
   // ---------------------------------------------------------------
   localparam logic [31:0] ARRAYS_LO = 32'hf0000000;
   localparam logic [31:0] ARRAYS_HI = 32'hf7ffffff;
   localparam logic [31:0] SQ_LO = 32'he0000000;
   localparam logic [31:0] SQ_HI = 32'he3ffffff;

   typedef enum logic [1:0] {
      REGION_EXTERNAL = 2'h0,
      REGION_ARRAYS = 2'h1,
      REGION_STORE_QUEUE = 2'h2
   } region_e;

   // ---------------------------------------------------------------
   // decoded operations
   // ---------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NONE = 5'h00,
      OP_LOAD_STATUS = 5'h01,
      OP_LOAD_GLOBAL_BASE = 5'h02,
      OP_LOAD_VECTOR_BASE = 5'h03,
      OP_LOAD_SAVED_STATUS = 5'h04,
      OP_LOAD_SAVED_PC = 5'h05,
      OP_LOAD_DEBUG_BASE = 5'h06,
      OP_LOAD_BANKED = 5'h07,
      OP_POP_STATUS = 5'h08,
      OP_POP_BANKED = 5'h09,
      OP_LOAD_MUL_ACC_LOW = 5'h0a,
      OP_POP_LINK = 5'h0b,
      OP_STORE_ALLOC = 5'h0c,
      OP_NOP = 5'h0d,
      OP_LINE_INVAL = 5'h0e,
      OP_LINE_PURGE = 5'h0f,
      OP_LINE_WRITEBACK = 5'h10,
      OP_FILL_HINT = 5'h11,
      OP_LOGIC_OR = 5'h12,
      OP_UNDEF = 5'h13
   } op_e;

   typedef struct packed {
      logic [15:0] mask;
      logic [15:0] match;
      op_e op;
      logic priv;
      logic t_from_lsb;
      logic post_inc;
   } pat_s;

   localparam int NUM_PATS = 18;
   localparam logic [5:0] POST_INC_STEP = 6'h04;

   localparam pat_s PATS [NUM_PATS] = '{
      '{16'hf0ff, 16'h400e, OP_LOAD_STATUS, 1'b1, 1'b1, 1'b0},
      '{16'hf0ff, 16'h401e, OP_LOAD_GLOBAL_BASE, 1'b0, 1'b0, 1'b0},
      '{16'hf0ff, 16'h402e, OP_LOAD_VECTOR_BASE, 1'b1, 1'b0, 1'b0},
      '{16'hf0ff, 16'h403e, OP_LOAD_SAVED_STATUS, 1'b1, 1'b0, 1'b0},
      '{16'hf0ff, 16'h404e, OP_LOAD_SAVED_PC, 1'b1, 1'b0, 1'b0},
      '{16'hf0ff, 16'h40fa, OP_LOAD_DEBUG_BASE, 1'b1, 1'b0, 1'b0},
      '{16'hf08f, 16'h408e, OP_LOAD_BANKED, 1'b1, 1'b0, 1'b0},
      '{16'hf0ff, 16'h4007, OP_POP_STATUS, 1'b1, 1'b1, 1'b1},
      '{16'hf08f, 16'h4087, OP_POP_BANKED, 1'b1, 1'b0, 1'b1},
      '{16'hf0ff, 16'h401a, OP_LOAD_MUL_ACC_LOW, 1'b0, 1'b0, 1'b0},
      '{16'hf0ff, 16'h4026, OP_POP_LINK, 1'b0, 1'b0, 1'b1},
      '{16'hf0ff, 16'h00c3, OP_STORE_ALLOC, 1'b0, 1'b0, 1'b0},
      '{16'hffff, 16'h0009, OP_NOP, 1'b0, 1'b0, 1'b0},
      '{16'hf0ff, 16'h0093, OP_LINE_INVAL, 1'b0, 1'b0, 1'b0},
      '{16'hf0ff, 16'h00a3, OP_LINE_PURGE, 1'b0, 1'b0, 1'b0},
      '{16'hf0ff, 16'h00b3, OP_LINE_WRITEBACK, 1'b0, 1'b0, 1'b0},
      '{16'hf0ff, 16'h0083, OP_FILL_HINT, 1'b0, 1'b0, 1'b0},
      '{16'hf00f, 16'h200b, OP_LOGIC_OR, 1'b0, 1'b0, 1'b0}
   };

   localparam logic [15:0] UNDEF_FIXED = 16'hfffd;
   localparam logic [15:0] UNDEF_DP_MASK = 16'hf00f;
   localparam logic [15:0] UNDEF_DP_MATCH = 16'hf00e;

   // one decoded slot
   typedef struct packed {
      logic valid;
      op_e op;
      logic [3:0] src;
      logic [3:0] dst;
      logic [2:0] bank;
      logic priv_fault;
      logic undef;
      logic t_from_lsb;
      logic post_inc;
   } dec_s;

   // address request and answer
   typedef struct packed {
      logic req;
      logic [31:0] base;
      logic [3:0] disp;
      logic [1:0] size;
   } ea_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] phys;
      logic [SPACE_ID_W-1:0] space_id;
      logic space_valid;
      region_e region;
   } ea_ans_s;

endpackage

// [sysctl_checker.sv]
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module sysctl_checker #(
   parameter int INSN_W = 16,
   parameter int DISP_W = 4
) (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pready, // apb ready
   input wire logic insn0_valid, // slot0 present
   input wire logic [INSN_W-1:0] insn0, // older word
   input wire logic insn1_valid, // slot1 present
   input wire logic [INSN_W-1:0] insn1, // younger word
   input wire sysctl_pkg::ea_req_s ea_in, // address request
   input wire sysctl_pkg::dec_s dec0, // slot0 decode
   input wire sysctl_pkg::dec_s dec1, // slot1 decode
   input wire logic [1:0] issue_count, // words issued
   input wire logic exc_illegal, // fault pulse
   input wire logic exc_undef, // undefined pulse
   input wire sysctl_pkg::ea_ans_s ea_out // address answer
);
   import sysctl_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----
   // properties
   // ----
   AST_APB_WAIT: assert property ($rose(penable) && psel |=> pready ##1 !pready)
      else $error("apb answer not one wait state");
   AST_STATUS_LOAD: assert property (
      insn0_valid && (insn0 & 16'hf0ff) == 16'h400e |=> dec0.priv_fault ||
      (dec0.op == OP_LOAD_STATUS && dec0.t_from_lsb))
      else $error("status load decode wrong");
   AST_PRIV_FAULT: assert property (
      dec0.priv_fault |-> exc_illegal && dec0.op == OP_NONE)
      else $error("privilege fault not suppressed");
   AST_UNDEF_CODE: assert property (
      insn0_valid && insn0 == 16'hfffd |=> dec0.undef && exc_undef)
      else $error("fixed undefined code missed");
   AST_OR_SPLIT: assert property (
      insn0_valid && insn1_valid && (insn0 & 16'hf00f) == 16'h200b &&
      (insn1 & 16'hf00f) == 16'h200b |=> issue_count == 2'h1 && !dec1.valid)
      else $error("or pair issued together");
   AST_NOP_PAIR: assert property (
      insn0_valid && insn1_valid && insn0 == 16'h0009 && insn1 == 16'h0009
      |=> issue_count == 2'h2 && dec1.op == OP_NOP)
      else $error("nop pair not dual issued");
   AST_SQ_WINDOW: assert property (
      ea_in.req && ea_in.base[31:26] == 6'h38 && ea_in.base[25:8] != 18'h3ffff
      |=> ea_out.region == REGION_STORE_QUEUE)
      else $error("store queue window missed");
   AST_DISP_SCALE: assert property (
      ea_in.req && ea_in.base[31:12] == 20'hf0000 |=> ea_out.valid &&
      ea_out.region == REGION_ARRAYS && ea_out.phys == $past(ea_in.base) +
      ({28'h0, $past(ea_in.disp)} << $past(ea_in.size)))
      else $error("scaled array address wrong");
   AST_POST_INC: assert property (
      dec0.valid && !dec0.priv_fault |-> dec0.post_inc ==
      (dec0.op inside {OP_POP_STATUS, OP_POP_BANKED, OP_POP_LINK}))
      else $error("post increment flag wrong");
   COV_FAULT: cover property (exc_illegal);
   COV_UNDEF: cover property (exc_undef);
   COV_DUAL: cover property (issue_count == 2'h2);
   COV_SQ: cover property (ea_out.region == REGION_STORE_QUEUE);
endmodule

bind system_control_insn_decoder sysctl_checker #(
   .INSN_W(INSN_W), .DISP_W(DISP_W)) u_chk (.pclk, .presetn, .psel,
   .penable, .pready, .insn0_valid, .insn0, .insn1_valid, .insn1, .ea_in,
   .dec0, .dec1, .issue_count, .exc_illegal, .exc_undef, .ea_out);

// [fetch_model.sv]
// fetch side model presenting instruction pairs
`timescale 1ns/1ps
module fetch_model (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, low
   input wire logic hold, // stall fetch
   input wire logic [1:0] issue_count, // words taken
   output logic insn0_valid, // slot0 present
   output logic [15:0] insn0, // older word
   output logic insn1_valid, // slot1 present
   output logic [15:0] insn1 // younger word
);
   logic [15:0] q [$];
   logic [1:0] ph;
   // lines idle at the inverse of the last word
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph <= 2'h0;
         insn0_valid <= 1'b0;
         insn1_valid <= 1'b0;
         insn0 <= 16'h0;
         insn1 <= 16'h0;
      end else if (ph == 2'h0) begin
         if (!hold && q.size() > 0) begin
            insn0_valid <= 1'b1;
            insn0 <= q[0];
            insn1_valid <= q.size() > 1;
            insn1 <= (q.size() > 1) ? q[1] : ~insn1;
            ph <= 2'h1;
         end
      end else if (ph == 2'h1) begin
         insn0_valid <= 1'b0;
         insn1_valid <= 1'b0;
         insn0 <= ~insn0;
         insn1 <= ~insn1;
         ph <= 2'h2;
      end else begin
         // unissued words stay at the head and go again
         repeat (issue_count) void'(q.pop_front());
         ph <= 2'h0;
      end
   end
endmodule

// [system_control_insn_decoder_tb_top.sv]
// self-checking bench for the system-control decoder
`timescale 1ns/1ps
module system_control_insn_decoder_tb_top;
   import sysctl_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, hold;
   logic [31:0] paddr, pwdata, prdata, rd, frame, peh;
   logic insn0_valid, insn1_valid, exc_illegal, exc_undef;
   logic [15:0] insn0, insn1;
   logic [1:0] issue_count;
   logic [3:0] ctrl_m;
   ea_req_s ea_in;
   dec_s dec0, dec1;
   ea_ans_s ea_out;
   int n_fail, checked;
   logic [31:0] pat [24] = '{32'h400e0f00, 32'h401e0f00, 32'h402e0f00,
      32'h403e0f00, 32'h404e0f00, 32'h40fa0f00, 32'h408e0f70, 32'h40070f00,
      32'h40870f70, 32'h401a0f00, 32'h40260f00, 32'h00c30f00, 32'h00090000,
      32'h00090000, 32'h00090000, 32'h00930f00, 32'h00a30f00, 32'h00b30f00,
      32'h00830f00, 32'h200b0ff0, 32'h200b0ff0, 32'h200b0ff0, 32'hfffd0000,
      32'hf00e0ff0};
   logic [31:0] bases [6] = '{32'hf0000000, 32'hf7fffff8, 32'he3fffff0,
      32'he0000000, 32'hdffffffc, 32'hefffff90};
   logic [3:0] modes [6] = '{4'h8, 4'h0, 4'h4, 4'h1, 4'h3, 4'hd};

   system_control_insn_decoder u_dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .insn0_valid,
      .insn0, .insn1_valid, .insn1, .ea_in, .dec0, .dec1, .issue_count,
      .exc_illegal, .exc_undef, .ea_out);
   fetch_model u_fetch (.pclk, .presetn, .hold, .issue_count, .insn0_valid,
      .insn0, .insn1_valid, .insn1);

   // ----
   // expectations
   // ----
   function automatic dec_s mk(logic [15:0] w);
      dec_s d;
      d = '0;
      d.src = w[7:4];
      d.dst = w[11:8];
      d.bank = w[6:4];
      casez (w)
         16'h4?0e: d.op = OP_LOAD_STATUS;
         16'h4?1e: d.op = OP_LOAD_GLOBAL_BASE;
         16'h4?2e: d.op = OP_LOAD_VECTOR_BASE;
         16'h4?3e: d.op = OP_LOAD_SAVED_STATUS;
         16'h4?4e: d.op = OP_LOAD_SAVED_PC;
         16'h4?fa: d.op = OP_LOAD_DEBUG_BASE;
         16'b0100????1???1110: d.op = OP_LOAD_BANKED;
         16'h4?07: d.op = OP_POP_STATUS;
         16'b0100????1???0111: d.op = OP_POP_BANKED;
         16'h4?1a: d.op = OP_LOAD_MUL_ACC_LOW;
         16'h4?26: d.op = OP_POP_LINK;
         16'h0?c3: d.op = OP_STORE_ALLOC;
         16'h0009: d.op = OP_NOP;
         16'h0?93: d.op = OP_LINE_INVAL;
         16'h0?a3: d.op = OP_LINE_PURGE;
         16'h0?b3: d.op = OP_LINE_WRITEBACK;
         16'h0?83: d.op = OP_FILL_HINT;
         16'h2??b: d.op = OP_LOGIC_OR;
         default: d.op = OP_NONE;
      endcase
      d.t_from_lsb = d.op inside {OP_LOAD_STATUS, OP_POP_STATUS};
      d.post_inc = d.op inside {OP_POP_STATUS, OP_POP_BANKED, OP_POP_LINK};
      if (w == 16'hfffd || (ctrl_m[2] && w[15:12] == 4'hf && w[3:0] == 4'he))
      begin
         d.op = OP_UNDEF;
         d.undef = 1'b1;
      end else if (ctrl_m[3] && d.op inside {OP_LOAD_STATUS,
         OP_LOAD_VECTOR_BASE, OP_LOAD_SAVED_STATUS, OP_LOAD_SAVED_PC,
         OP_LOAD_DEBUG_BASE, OP_LOAD_BANKED, OP_POP_STATUS, OP_POP_BANKED})
      begin
         d.op = OP_NONE;
         d.priv_fault = 1'b1;
      end
      return d;
   endfunction

   function automatic ea_ans_s mkea(ea_req_s r);
      ea_ans_s a;
      logic [31:0] v;
      a = '0;
      v = r.base + ({28'h0, r.disp} << r.size);
      if (r.req) begin
         a.valid = 1'b1;
         a.phys = v;
         if (v >= 32'hf0000000 && v <= 32'hf7ffffff) a.region = REGION_ARRAYS;
         else if (v >= 32'he0000000 && v <= 32'he3ffffff)
            a.region = REGION_STORE_QUEUE;
         else if (ctrl_m[0]) a.phys = {frame[31:12], v[11:0]};
         if (ctrl_m[0] && !ctrl_m[1]) begin
            a.space_valid = 1'b1;
            a.space_id = peh[7:0];
         end
      end
      return a;
   endfunction

   task automatic chk(input string s, input logic [63:0] e, g);
      checked++;
      if (e !== g) begin
         n_fail++;
         $display("Error %s expected %0h seen %0h", s, e, g);
      end
   endtask

   task automatic cmp(input string s, input dec_s e, g);
      chk(s, {e.op, e.priv_fault, e.undef, e.src, e.dst, e.bank}, {g.op,
         g.priv_fault, g.undef, g.src, g.dst, g.bank});
      if (!e.priv_fault && !e.undef)
         chk(s, {e.t_from_lsb, e.post_inc}, {g.t_from_lsb, g.post_inc});
   endtask

   task end_of_test;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [31:0] a, d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      if (pready !== 1'b1) begin
         n_fail++;
         end_of_test;
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ----
   // monitor and stimulus
   // ----
   always @(posedge pclk) hold <= ($urandom % 3) == 0;

   always @(posedge pclk) begin
      dec_s e0, e1;
      ea_ans_s ea;
      logic v0, v1, i1, on;
      on = presetn;
      v0 = insn0_valid;
      v1 = insn1_valid;
      e0 = mk(insn0);
      e1 = mk(insn1);
      ea = mkea(ea_in);
      i1 = v0 && v1 && !e0.priv_fault && !e0.undef &&
         !(e0.op == OP_LOGIC_OR && e1.op == OP_LOGIC_OR);
      #1;
      if (on) begin
         chk("issue_count", 2'(v0) + 2'(i1), issue_count);
         chk("dec0.valid", v0, dec0.valid);
         if (v0) cmp("dec0", e0, dec0);
         chk("dec1.valid", i1, dec1.valid);
         if (i1) cmp("dec1", e1, dec1);
         chk("exc", {(v0 & e0.priv_fault) | (i1 & e1.priv_fault),
            (v0 & e0.undef) | (i1 & e1.undef)},
            {exc_illegal, exc_undef});
         chk("ea_out", ea, ea_out);
      end
   end

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial begin
      #1000000;
      n_fail++;
      end_of_test;
   end

   initial begin
      int n, k;
      {psel, penable, pwrite, hold, presetn} = '0;
      {paddr, pwdata, frame, peh} = '0;
      ea_in = '0;
      n_fail = 0;
      checked = 0;
      ctrl_m = CTRL_RESET;
      n = $urandom(32'h6500c95b);
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, {24'h0, OFF_CTRL}, 32'h0, rd, er);
      chk("ctrl", {CTRL_RESET, 1'b0}, {rd, er});
      apb(1'b0, 32'h10, 32'h0, rd, er);
      chk("unmapped", 64'h1, {rd, er});
      for (k = 0; k < 6; k++) begin
         frame = $urandom;
         peh = $urandom;
         ctrl_m = modes[k];
         apb(1'b1, {24'h0, OFF_FRAME}, frame, rd, er);
         apb(1'b1, {24'h0, OFF_PAGE_ENTRY_HIGH}, peh, rd, er);
         apb(1'b1, {24'h0, OFF_CTRL}, {28'h0, ctrl_m}, rd, er);
         foreach (pat[i])
            u_fetch.q.push_back(pat[i][31:16] | (16'($urandom) & pat[i][15:0]));
         repeat (16) u_fetch.q.push_back(16'($urandom));
         n = 0;
         while ((u_fetch.q.size() != 0 || u_fetch.ph != 2'h0) && n < 5000) begin
            @(posedge pclk);
            n++;
         end
         if (n >= 5000) begin
            n_fail++;
            end_of_test;
         end
         for (n = 0; n < 30; n++) begin
            @(posedge pclk);
            ea_in <= '{req: ($urandom % 4) != 0,
               base: (n < 6) ? bases[n] : $urandom,
               disp: 4'($urandom), size: 2'($urandom)};
         end
         @(posedge pclk);
         ea_in <= '0;
         repeat (2) @(posedge pclk);
      end
      end_of_test;
   end
endmodule
